/* hw/tcpd_base_clock.sv */
/*
 * tcpd_base_clock: generates the one-cycle basic clock tick.
 * assumes ref_clk_i at 100 MHz; tick rate picked by a level input.
 */
`timescale 1ns/1ps
module tcpd_base_clock
    import tcpd_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    // control
    input  wire logic slow_i,
    // tick out
    output logic      tick_o
);
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] div_nxt;
    wire  [DIV_W-1:0] div_last = slow_i ? DIV_W'(SLOW_DIV - 1) : DIV_W'(FAST_DIV - 1);
    wire              div_wrap = (div_r >= div_last);

    // divider restarts as soon as it reaches the selected end
    assign div_nxt = div_wrap ? '0 : div_r + DIV_W'(1);
    assign tick_o  = div_wrap;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) div_r <= '0;
        else         div_r <= div_nxt;
    end
endmodule : tcpd_base_clock

/* hw/tcpd_pkg.sv */
/*
 * tcpd_pkg: constants for the three-channel pwm converter block.
 * assumes a 100 MHz reference clock and a word-wide register transfer port.
 */
package tcpd_pkg;
    // ************************************************************
    // register addresses and fields
    // ************************************************************
    localparam logic [7:0]  ADDR_DUTY_CH0    = 8'h44;
    localparam logic [7:0]  ADDR_DUTY_CH1    = 8'h45;
    localparam logic [7:0]  ADDR_DUTY_CH2    = 8'h46;
    localparam logic [8:0]  DUTY_RESET       = 9'h1ff;
    localparam int          DUTY_W           = 9;
    localparam int          WORD_W           = 16;
    localparam int          CKSEL_WIDTH_BIT  = 2;
    localparam int          CKSEL_FREQ_BIT   = 0;
    localparam int          NUM_CH           = 3;
    // ************************************************************
    // timing: basic clock from 100 MHz reference
    // ************************************************************
    localparam int          REF_CLK_HZ       = 100_000_000;
    localparam int          FAST_BASE_HZ     = 1_125_000;
    localparam int          SLOW_BASE_HZ     = 112_500;
    // each period rounds down
    localparam int          FAST_DIV         = REF_CLK_HZ / FAST_BASE_HZ;
    localparam int          SLOW_DIV         = REF_CLK_HZ / SLOW_BASE_HZ;
    localparam int          DIV_W            = 10;
    // phase offsets between channels, in counter steps
    localparam logic [8:0]  PHASE_STEP       = 9'h055;
endpackage : tcpd_pkg

/* hw/tcpd_pwm_dac.sv */
/*
 * tcpd_pwm_dac: three-channel pwm converter with open-drain outputs.
 *
 * signal flow: a divider makes the basic clock tick, one shared counter
 * steps on every tick, each channel adds its own phase to that count and
 * compares the result with its duty register; the comparator result is
 * registered, then routed either to the pin or replaced by the port latch.
 *
 * assumes an external pull-up and low-pass filter on each pin, a processor
 * transfer port moving 16-bit words to and from the buffer, and control
 * inputs that are synchronous to ref_clk_i.
 */
// limitations worth knowing:
// - halt and chip-enable reset are accepted but change nothing
// - clock stop holds every duty at its reset value while it stands
// - the divider rounds down, so the basic clock runs slightly fast
// - the quarter pulse is rounded down to whole reference cycles
// - a width or rate change mid-period gives one irregular period
// - channel 2 storage is the timer modulo; never run both at once
// - unmapped reads return zero and unmapped writes are dropped
// - a duty write acts on the next comparison, not at the wrap
// - pins lag the comparator by two register stages
// - watchdog reset restarts the shared count from zero
// - the bench of flags is level based; no flag is latched here
// - open drain: a high pin level relies on the external pull-up
`timescale 1ns/1ps
module tcpd_pwm_dac
    import tcpd_pkg::*;
(
    // clock and resets
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic              watchdog_stack_reset_i,
    input  wire logic              chip_enable_reset_i,
    input  wire logic              clock_stop_i,
    input  wire logic              halt_i,
    // register transfer port
    input  wire logic [7:0]        reg_addr_i,
    input  wire logic              reg_put_i,
    input  wire logic              reg_get_i,
    input  wire logic [WORD_W-1:0] transfer_buffer_i,
    output logic [WORD_W-1:0]      transfer_buffer_o,
    output logic                   transfer_hit_o,
    // configuration flags
    input  wire logic [3:0]        clock_select_i,
    input  wire logic [NUM_CH-1:0] function_select_i,
    input  wire logic              timer_or_converter_select_i,
    input  wire logic [NUM_CH-1:0] port_latch_i,
    // open-drain pins
    output logic [NUM_CH-1:0]      duty_out_o,
    output logic [NUM_CH-1:0]      duty_out_oe_o,
    // duty storage seen by the timer
    output logic [DUTY_W-1:0]      timer_modulo_o
);
    // ************************************************************
    // decoding
    // ************************************************************
    function automatic logic [1:0] addr_to_ch(input logic [7:0] a);
        case (a)
            ADDR_DUTY_CH0: addr_to_ch = 2'd0;
            ADDR_DUTY_CH1: addr_to_ch = 2'd1;
            ADDR_DUTY_CH2: addr_to_ch = 2'd2;
            default:       addr_to_ch = 2'd3;
        endcase
    endfunction : addr_to_ch

    // 8-bit mode looks only at the low byte of count and duty alike
    function automatic logic [8:0] width_view(input logic [8:0] v, input logic nine);
        width_view = nine ? v : {1'b0, v[7:0]};
    endfunction : width_view

    wire [1:0] sel_ch     = addr_to_ch(reg_addr_i);
    wire       addr_hit   = (sel_ch != 2'd3);
    wire       timer_mode = timer_or_converter_select_i;
    wire       nine_bit   = clock_select_i[CKSEL_WIDTH_BIT];
    wire       slow_clk   = clock_select_i[CKSEL_FREQ_BIT];
    wire       duty_init  = watchdog_stack_reset_i | clock_stop_i;

    // halt and chip-enable reset are not stop conditions: the block runs on
    wire       frozen     = 1'b0 & (halt_i | chip_enable_reset_i);

    // ************************************************************
    // basic clock and shared counter
    // ************************************************************
    logic       tick;
    logic [8:0] count_r;
    logic [8:0] count_nxt;

    tcpd_base_clock u_base (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .slow_i    (slow_clk),
        .tick_o    (tick)
    );

    // one counter for all channels; 8-bit mode keeps bit 8 at zero
    assign count_nxt = !tick ? count_r :
                       (nine_bit ? count_r + 9'h001
                                 : {1'b0, count_r[7:0] + 8'h01});

    // ************************************************************
    // sub-step phase for the quarter-step offset
    // ************************************************************
    // high time extends by a quarter basic clock beyond the duty value
    logic [DIV_W-1:0] sub_r;
    wire  [DIV_W-1:0] quarter = slow_clk ? DIV_W'(SLOW_DIV / 4) : DIV_W'(FAST_DIV / 4);
    wire              in_quarter = (sub_r < quarter);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) sub_r <= '0;
        else         sub_r <= tick ? '0 : sub_r + DIV_W'(1);
    end

    // shared count; a watchdog reset starts a fresh period
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i)                              count_r <= '0;
        else if (watchdog_stack_reset_i | frozen) count_r <= '0;
        else                                      count_r <= count_nxt;
    end

    // ************************************************************
    // duty registers and comparators
    // ************************************************************
    logic [DUTY_W-1:0] duty_r [NUM_CH];
    logic [NUM_CH-1:0] cmp_r;
    logic [NUM_CH-1:0] cmp_nxt;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire              wr_me = reg_put_i & addr_hit & (sel_ch == 2'(g));
            wire [8:0]        phase = 9'(PHASE_STEP * g);
            // each channel sees the shared count shifted by its own phase
            wire [8:0]        pos9  = count_r + phase;
            wire [8:0]        pos   = width_view(pos9, nine_bit);
            wire [8:0]        dval  = width_view(duty_r[g], nine_bit);
            // greater-than gives high; equal still gives the quarter pulse
            assign cmp_nxt[g] = (dval > pos) | ((dval == pos) & in_quarter);

            // timer mode keeps ch0/ch1 as 8-bit latches; writes store low bits
            always_ff @(posedge ref_clk_i or posedge reset_i) begin
                if (reset_i)        duty_r[g] <= DUTY_RESET;
                else if (duty_init) duty_r[g] <= DUTY_RESET;
                else if (wr_me)     duty_r[g] <= (timer_mode && g < 2)
                                                 ? {1'b0, transfer_buffer_i[7:0]}
                                                 : transfer_buffer_i[DUTY_W-1:0];
            end
        end
    endgenerate

    // one stage here keeps compare glitches off the pins
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) cmp_r <= '0;
        else         cmp_r <= cmp_nxt;
    end

    // channel 2 register is the timer modulo storage
    assign timer_modulo_o = duty_r[2];

    // ************************************************************
    // read-back through the transfer buffer
    // ************************************************************
    logic [WORD_W-1:0] rd_r;
    // explicit select keeps the unmapped slot off the end of the array
    wire  [DUTY_W-1:0] rd_duty = (sel_ch == 2'd0) ? duty_r[0] :
                                 (sel_ch == 2'd1) ? duty_r[1] :
                                 (sel_ch == 2'd2) ? duty_r[2] : '0;

    wire  [WORD_W-1:0] rd_nxt = addr_hit ? {7'h00, rd_duty} : '0;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i)        rd_r <= '0;
        else if (reg_get_i) rd_r <= rd_nxt;
    end
    assign transfer_buffer_o = rd_r;

    // hit is combinational so the processor sees it in the request cycle
    assign transfer_hit_o    = addr_hit & (reg_put_i | reg_get_i);

    // ************************************************************
    // pin selection
    // ************************************************************
    // pins drive the latch in port mode; clock stop and timer override
    logic [NUM_CH-1:0] pin_r;
    logic [NUM_CH-1:0] pin_nxt;
    wire  [NUM_CH-1:0] pwm_sel = (timer_mode | clock_stop_i) ? '0 : function_select_i;

    assign pin_nxt = (pwm_sel & cmp_r) | (~pwm_sel & port_latch_i);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i)                     pin_r <= '0;
        else if (watchdog_stack_reset_i) pin_r <= '0;
        else                             pin_r <= pin_nxt;
    end

    // open drain: enable pulls low, a high level is left to the pull-up
    assign duty_out_o    = '0;
    assign duty_out_oe_o = ~pin_r;
endmodule : tcpd_pwm_dac

/* testbench/tb_three_channel_pwm_dac.sv */
/* tb_three_channel_pwm_dac: directed bench for tcpd_pwm_dac.
   assumes the pin load model and the bound checker. */
`timescale 1ns/1ps
module tb_three_channel_pwm_dac import tcpd_pkg::*;;
    logic ref_clk_i = 0, reset_i = 1, watchdog_stack_reset_i = 0, chip_enable_reset_i = 0, halt_i = 0;
    logic clock_stop_i = 0, reg_put_i = 0, reg_get_i = 0, timer_or_converter_select_i = 0, clr = 0;
    logic [7:0]  reg_addr_i = 8'h00;
    logic [15:0] transfer_buffer_i = 16'h0000;
    logic [3:0]  clock_select_i = 4'h0;
    logic [2:0]  function_select_i = 3'h0, port_latch_i = 3'h0;
    logic [15:0] transfer_buffer_o, hi0, hi1;
    logic [2:0]  duty_out_o, duty_out_oe_o, pin;
    logic [8:0]  timer_modulo_o;
    logic        transfer_hit_o;
    int          n_fail = 0, n_tests = 0, cyc = 0;
    tcpd_pwm_dac dut (.*);
    tcpd_pin_load u_load (.clk_i(ref_clk_i), .clr_i(clr), .oe_i(duty_out_oe_o), .dat_i(duty_out_o),
        .pin_o(pin), .hi0_o(hi0), .hi1_o(hi1));
    always #5 ref_clk_i = ~ref_clk_i;
    // hang guard, runs take about 68000 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            wrap_up();
        end
    end
    task wrap_up();
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task put_w(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        transfer_buffer_i = d;
        reg_put_i = 1;
        @(negedge ref_clk_i);
        reg_put_i = 0;
    endtask : put_w
    task get_w(input logic [7:0] a, input logic [15:0] exp);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_get_i = 1;
        @(negedge ref_clk_i);
        reg_get_i = 0;
        @(negedge ref_clk_i);
        chk(transfer_buffer_o, exp);
    endtask : get_w
    // clear the integrators, then sample exactly n cycles
    task measure(input int n);
        @(negedge ref_clk_i);
        clr = 1;
        @(negedge ref_clk_i);
        clr = 0;
        repeat (n) @(negedge ref_clk_i);
    endtask : measure
    task t_regs();
        for (int c = 0; c < 3; c++) get_w(ADDR_DUTY_CH0 + 8'(c), 16'h01ff);
        get_w(8'h47, 16'h0000);
        @(negedge ref_clk_i);
        reg_addr_i = ADDR_DUTY_CH2;
        reg_get_i = 1;
        #1 chk({15'h0, transfer_hit_o}, 16'h0001);
        @(negedge ref_clk_i);
        reg_addr_i = 8'h47;
        #1 chk({15'h0, transfer_hit_o}, 16'h0000);
        @(negedge ref_clk_i);
        reg_get_i = 0;
        put_w(ADDR_DUTY_CH0, 16'hffff);
        get_w(ADDR_DUTY_CH0, 16'h01ff);
        put_w(ADDR_DUTY_CH1, 16'h0080);
        get_w(ADDR_DUTY_CH1, 16'h0080);
    endtask : t_regs
    task t_pwm();
        function_select_i = 3'b111;
        put_w(ADDR_DUTY_CH0, 16'h0000);
        measure(256 * FAST_DIV);
        chk(hi0, 16'(FAST_DIV / 4));
        chk(hi1, 16'(128 * FAST_DIV + FAST_DIV / 4));
        clock_select_i = 4'h4;
        halt_i = 1;
        chip_enable_reset_i = 1;
        put_w(ADDR_DUTY_CH0, 16'h0100);
        put_w(ADDR_DUTY_CH1, 16'h01ff);
        measure(512 * FAST_DIV);
        chk(hi0, 16'(256 * FAST_DIV + FAST_DIV / 4));
        chk(hi1, 16'(511 * FAST_DIV + FAST_DIV / 4));
        halt_i = 0;
        chip_enable_reset_i = 0;
    endtask : t_pwm
    task t_modes();
        port_latch_i = 3'b101;
        clock_stop_i = 1;
        put_w(ADDR_DUTY_CH2, 16'h0010);
        repeat (4) @(negedge ref_clk_i);
        chk({13'h0, duty_out_oe_o}, 16'h0002);
        clock_stop_i = 0;
        get_w(ADDR_DUTY_CH2, 16'h01ff);
        timer_or_converter_select_i = 1;
        port_latch_i = 3'b011;
        put_w(ADDR_DUTY_CH0, 16'h01aa);
        repeat (4) @(negedge ref_clk_i);
        chk({13'h0, duty_out_oe_o}, 16'h0004);
        get_w(ADDR_DUTY_CH0, 16'h00aa);
        timer_or_converter_select_i = 0;
        function_select_i = 3'b000;
        port_latch_i = 3'b111;
        repeat (4) @(negedge ref_clk_i);
        chk({13'h0, duty_out_oe_o}, 16'h0000);
        watchdog_stack_reset_i = 1;
        @(negedge ref_clk_i);
        watchdog_stack_reset_i = 0;
        chk({13'h0, duty_out_oe_o}, 16'h0007);
        get_w(ADDR_DUTY_CH0, 16'h01ff);
    endtask : t_modes
    initial begin
        repeat (12) @(negedge ref_clk_i);
        reset_i = 0;
        t_regs();
        t_pwm();
        t_modes();
        wrap_up();
    end
endmodule : tb_three_channel_pwm_dac

/* testbench/tcpd_pin_load.sv */
/* tcpd_pin_load: pull-ups on the open-drain pins, filters on pins 0 and 1.
   assumes oe high pulls a pin to the data level. */
`timescale 1ns/1ps
module tcpd_pin_load (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic [2:0] oe_i,
    input  wire logic [2:0] dat_i,
    output logic [2:0]      pin_o,
    output logic [15:0]     hi0_o,
    output logic [15:0]     hi1_o
);
    // released pins float up to the pull-up level
    assign pin_o = (oe_i & dat_i) | ~oe_i;
    // high-time integrator stands in for the rc filter
    always @(posedge clk_i) begin
        hi0_o <= clr_i ? 16'h0000 : hi0_o + 16'(pin_o[0]);
        hi1_o <= clr_i ? 16'h0000 : hi1_o + 16'(pin_o[1]);
    end
endmodule : tcpd_pin_load

/* testbench/tcpd_pwm_dac_sva.sv */
/* tcpd_pwm_dac_sva: port checks for the pwm converter.
   assumes bind onto tcpd_pwm_dac, one clock domain. */
`timescale 1ns/1ps
module tcpd_pwm_dac_sva
    import tcpd_pkg::*;
(
    // clock and resets
    input wire logic        ref_clk_i,
    input wire logic        reset_i,
    input wire logic        watchdog_stack_reset_i,
    input wire logic        clock_stop_i,
    // transfer port
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_get_i,
    input wire logic [15:0] transfer_buffer_o,
    // pins and flags
    input wire logic [2:0]  function_select_i,
    input wire logic        timer_or_converter_select_i,
    input wire logic [2:0]  port_latch_i,
    input wire logic [2:0]  duty_out_o,
    input wire logic [2:0]  duty_out_oe_o,
    input wire logic [8:0]  timer_modulo_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // decoded map, unmapped gets must read zero
    wire map_w = reg_addr_i inside {ADDR_DUTY_CH0, ADDR_DUTY_CH1, ADDR_DUTY_CH2};
    pin_data_a: assert property (duty_out_o == 3'b000) else $error("pin data");
    wd_pins_a: assert property (watchdog_stack_reset_i |=> duty_out_oe_o == 3'b111)
        else $error("wd pins");
    wd_duty_a: assert property (watchdog_stack_reset_i |=> timer_modulo_o == DUTY_RESET)
        else $error("wd duty");
    stop_duty_a: assert property (clock_stop_i |=> timer_modulo_o == DUTY_RESET)
        else $error("stop duty");
    // pins lag the latch by one cycle; the latch must stand three
    stop_pins_a: assert property ((clock_stop_i && !watchdog_stack_reset_i && $stable(port_latch_i))[*3]
        |-> duty_out_oe_o == ~port_latch_i) else $error("stop pins");
    timer_pins_a: assert property ((timer_or_converter_select_i && !watchdog_stack_reset_i
        && $stable(port_latch_i))[*3] |-> duty_out_oe_o == ~port_latch_i) else $error("timer pins");
    sel_latch_a: assert property ((!function_select_i[0] && !watchdog_stack_reset_i
        && $stable(port_latch_i))[*3] |-> duty_out_oe_o[0] == ~port_latch_i[0]) else $error("sel pin");
    unmapped_a: assert property (reg_get_i && !map_w |=> transfer_buffer_o == 16'h0000)
        else $error("unmapped read");
    cover property (clock_stop_i[*3]);
    cover property (reg_get_i && map_w);
    cover property ($fell(duty_out_oe_o[1]));
endmodule : tcpd_pwm_dac_sva
bind tcpd_pwm_dac tcpd_pwm_dac_sva u_sva (.*);
